// [verilog/interrupt_enable_bank_lower.sv]
// interrupt enable banks 0 and 1 with pending flags, AXI4-Lite slave
//
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "irq_enable_defs.svh"

// Functional notes
// (R1) enable bit 1 passes its source request, 0 blocks it
// (R2) all implemented enable bits read/write, zero after reset
// (R3) bank0 bit 15 and bank1 bit 2 read zero, ignore writes
// (R4) bank0 bit 14 DMA channel 1 done, bit 13 ADC1 done
// (R5) bank0 bit 12 UART1 transmit, bit 11 UART1 receive
// (R6) bank0 bit 10 SPI1 event, bit 9 SPI1 error
// (R7) bank0 bit 8 Timer3, bit 7 Timer2
// (R8) bank0 bit 6 output compare 2, bit 5 input capture 2
// (R9) bank0 bit 4 DMA channel 0 done, bit 3 Timer1
// (R10) bank0 bits 2,1,0: output compare 1, input capture 1, pin 0
// (R11) bank1 bits 15,14: UART2 transmit and UART2 receive
// (R12) bank1 bits 13,12,11: external pin 2, Timer5, Timer4
// (R13) bank1 bits 10,9,8: output compare 4, 3, DMA channel 2
// (R14) bank1 bit 7 input capture 8, bit 6 input capture 7
// (R15) bank1 bit 5 ADC2 done, bit 4 external pin 1
// (R16) bank1 bit 3 change notify, bit 1 I2C1 master, bit 0 slave
// (R17) each source has a sticky flag set by its request
// (R18) request out is flag AND enable; enable never clears flag
// (R19) enable write acts at completing edge, output next cycle
module interrupt_enable_bank_lower
	import irq_enable_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [31:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic [15:0] src_req0,
	input wire logic [15:0] src_req1,
	output bank0_t gated_req0,
	output bank1_t gated_req1,
	output logic irq
);

	// ==========================================================
	// state
	bank0_t en0_q;
	bank0_t en0_d;
	bank1_t en1_q;
	bank1_t en1_d;
	bank0_t flag0_q;
	bank0_t flag0_d;
	bank1_t flag1_q;
	bank1_t flag1_d;
	wr_req_t wreq_q;
	logic aw_full_q;
	logic w_full_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [1:0] rresp_q;
	logic [31:0] rdata_q;

	// ==========================================================
	// write path decode
	wire aw_take = awvalid && awready;
	wire w_take = wvalid && wready;
	wire wr_fire = aw_full_q && w_full_q && !bvalid_q;
	wire sel_en0 = wreq_q.addr == `IEB_EN0_ADDR;
	wire sel_en1 = wreq_q.addr == `IEB_EN1_ADDR;
	wire sel_fl0 = wreq_q.addr == `IEB_FL0_ADDR;
	wire sel_fl1 = wreq_q.addr == `IEB_FL1_ADDR;
	wire wr_hit = sel_en0 || sel_en1 || sel_fl0 || sel_fl1;
	wire [15:0] bmask = {{8{wreq_q.strb[1]}}, {8{wreq_q.strb[0]}}};
	wire [15:0] wval = wreq_q.data[15:0];
	wire [15:0] merge0 = (en0_q & ~bmask) | (wval & bmask);
	wire [15:0] merge1 = (en1_q & ~bmask) | (wval & bmask);
	wire [15:0] clr0 = (wr_fire && sel_fl0) ? (wval & bmask) : 16'h0000;
	wire [15:0] clr1 = (wr_fire && sel_fl1) ? (wval & bmask) : 16'h0000;

	// ==========================================================
	// read path decode
	wire ar_take = arvalid && arready;
	wire rsel_en0 = araddr == `IEB_EN0_ADDR;
	wire rsel_en1 = araddr == `IEB_EN1_ADDR;
	wire rsel_fl0 = araddr == `IEB_FL0_ADDR;
	wire rsel_fl1 = araddr == `IEB_FL1_ADDR;
	wire rd_hit = rsel_en0 || rsel_en1 || rsel_fl0 || rsel_fl1;
	wire [15:0] rd_val = rsel_en0 ? en0_q :
		rsel_en1 ? en1_q :
		rsel_fl0 ? flag0_q :
		rsel_fl1 ? flag1_q : 16'h0000;

	// ==========================================================
	// next values of enables and flags
	// masking by the implemented set keeps reserved bits at zero
	assign en0_d = (wr_fire && sel_en0) ?
		bank0_t'(merge0 & `IEB_IMPL0) : en0_q; // R2 R3 R19
	assign en1_d = (wr_fire && sel_en1) ?
		bank1_t'(merge1 & `IEB_IMPL1) : en1_q; // R2 R3 R19
	// a request in the clearing cycle wins over the clear
	assign flag0_d = bank0_t'(((flag0_q & ~clr0) | src_req0)
		& `IEB_IMPL0); // R17 R18
	assign flag1_d = bank1_t'(((flag1_q & ~clr1) | src_req1)
		& `IEB_IMPL1); // R17 R18

	// ==========================================================
	// bus handshakes
	assign awready = !aw_full_q;
	assign wready = !w_full_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = !rvalid_q;
	assign rvalid = rvalid_q;
	assign rresp = rresp_q;
	assign rdata = rdata_q;

	// ==========================================================
	// register bank
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			en0_q <= bank0_t'(`IEB_EN_RST); // R2
			en1_q <= bank1_t'(`IEB_EN_RST); // R2
			flag0_q <= bank0_t'(`IEB_FL_RST);
			flag1_q <= bank1_t'(`IEB_FL_RST);
		end else begin
			en0_q <= en0_d;
			en1_q <= en1_d;
			flag0_q <= flag0_d;
			flag1_q <= flag1_d;
		end
	end

	// ==========================================================
	// write channel holding
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			wreq_q <= '0;
		end else begin
			if (aw_take) begin
				aw_full_q <= 1'b1;
				wreq_q.addr <= awaddr;
			end else if (wr_fire) begin
				aw_full_q <= 1'b0;
			end
			if (w_take) begin
				w_full_q <= 1'b1;
				wreq_q.data <= wdata;
				wreq_q.strb <= wstrb;
			end else if (wr_fire) begin
				w_full_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q <= `IEB_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q <= wr_hit ? `IEB_RESP_OKAY : `IEB_RESP_SLVERR;
		end else if (bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// ==========================================================
	// read response
	// unmapped reads answer zero with a slave error
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rresp_q <= `IEB_RESP_OKAY;
			rdata_q <= `IEB_RDATA_RST;
		end else if (ar_take) begin
			rvalid_q <= 1'b1;
			rresp_q <= rd_hit ? `IEB_RESP_OKAY : `IEB_RESP_SLVERR;
			rdata_q <= {16'h0000, rd_val}; // R2 R3
		end else if (rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// ==========================================================
	// bank 0 gating, one source per bit
	assign gated_req0.rsvd15 = 1'b0; // R3
	assign gated_req0.dma_ch1_done_en =
		flag0_q.dma_ch1_done_en & en0_q.dma_ch1_done_en; // R4
	assign gated_req0.adc_unit1_done_en =
		flag0_q.adc_unit1_done_en & en0_q.adc_unit1_done_en; // R4
	assign gated_req0.uart_one_tx_en =
		flag0_q.uart_one_tx_en & en0_q.uart_one_tx_en; // R5
	assign gated_req0.uart_one_rx_en =
		flag0_q.uart_one_rx_en & en0_q.uart_one_rx_en; // R5
	assign gated_req0.spi_one_event_en =
		flag0_q.spi_one_event_en & en0_q.spi_one_event_en; // R6
	assign gated_req0.spi_one_error_en =
		flag0_q.spi_one_error_en & en0_q.spi_one_error_en; // R6
	assign gated_req0.timer_three_en =
		flag0_q.timer_three_en & en0_q.timer_three_en; // R7
	assign gated_req0.timer_two_en =
		flag0_q.timer_two_en & en0_q.timer_two_en; // R7
	assign gated_req0.out_compare_two_en =
		flag0_q.out_compare_two_en & en0_q.out_compare_two_en; // R8
	assign gated_req0.in_capture_two_en =
		flag0_q.in_capture_two_en & en0_q.in_capture_two_en; // R8
	assign gated_req0.dma_ch0_done_en =
		flag0_q.dma_ch0_done_en & en0_q.dma_ch0_done_en; // R9
	assign gated_req0.timer_one_en =
		flag0_q.timer_one_en & en0_q.timer_one_en; // R9
	assign gated_req0.out_compare_one_en =
		flag0_q.out_compare_one_en & en0_q.out_compare_one_en; // R10
	assign gated_req0.in_capture_one_en =
		flag0_q.in_capture_one_en & en0_q.in_capture_one_en; // R10
	assign gated_req0.ext_pin0_irq_en =
		flag0_q.ext_pin0_irq_en & en0_q.ext_pin0_irq_en; // R10

	// ==========================================================
	// bank 1 gating, one source per bit
	assign gated_req1.uart_two_tx_en =
		flag1_q.uart_two_tx_en & en1_q.uart_two_tx_en; // R11
	assign gated_req1.uart_two_rx_en =
		flag1_q.uart_two_rx_en & en1_q.uart_two_rx_en; // R11
	assign gated_req1.ext_pin2_irq_en =
		flag1_q.ext_pin2_irq_en & en1_q.ext_pin2_irq_en; // R12
	assign gated_req1.timer_five_en =
		flag1_q.timer_five_en & en1_q.timer_five_en; // R12
	assign gated_req1.timer_four_en =
		flag1_q.timer_four_en & en1_q.timer_four_en; // R12
	assign gated_req1.out_compare_four_en =
		flag1_q.out_compare_four_en & en1_q.out_compare_four_en; // R13
	assign gated_req1.out_compare_three_en =
		flag1_q.out_compare_three_en &
		en1_q.out_compare_three_en; // R13
	assign gated_req1.dma_ch2_done_en =
		flag1_q.dma_ch2_done_en & en1_q.dma_ch2_done_en; // R13
	assign gated_req1.in_capture_eight_en =
		flag1_q.in_capture_eight_en & en1_q.in_capture_eight_en; // R14
	assign gated_req1.in_capture_seven_en =
		flag1_q.in_capture_seven_en & en1_q.in_capture_seven_en; // R14
	assign gated_req1.adc_unit2_done_en =
		flag1_q.adc_unit2_done_en & en1_q.adc_unit2_done_en; // R15
	assign gated_req1.ext_pin1_irq_en =
		flag1_q.ext_pin1_irq_en & en1_q.ext_pin1_irq_en; // R15
	assign gated_req1.pin_change_notify_en =
		flag1_q.pin_change_notify_en &
		en1_q.pin_change_notify_en; // R16
	assign gated_req1.rsvd2 = 1'b0; // R3
	assign gated_req1.i2c_one_master_en =
		flag1_q.i2c_one_master_en & en1_q.i2c_one_master_en; // R16
	assign gated_req1.i2c_one_slave_en =
		flag1_q.i2c_one_slave_en & en1_q.i2c_one_slave_en; // R16

	// one level line for the whole bank
	assign irq = |{gated_req0, gated_req1}; // R1 R18

	// ==========================================================
	// checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_en0_write_full: assert property ( // R2 R19
		wr_fire && sel_en0 && wreq_q.strb[1:0] == 2'h3 |=>
		en0_q == ($past(wreq_q.data[15:0]) & `IEB_IMPL0))
	else $error("bank 0 enable did not take written value");

	chk_en1_low_lane: assert property ( // R2 R19
		wr_fire && sel_en1 && wreq_q.strb[1:0] == 2'h1 |=>
		en1_q[15:8] == $past(en1_q[15:8]) &&
		en1_q[7:0] == ($past(wreq_q.data[7:0]) & 8'hFB))
	else $error("bank 1 low lane write wrong");

	chk_reserved_zero: assert property ( // R3
		!en0_q.rsvd15 && !en1_q.rsvd2 &&
		!flag0_q.rsvd15 && !flag1_q.rsvd2)
	else $error("reserved bit set");

	chk_reset_clears: assert property ( // R2
		$rose(aresetn) |-> en0_q == 16'h0000 && en1_q == 16'h0000)
	else $error("enables not cleared by reset");

	chk_flag_sets: assert property ( // R17
		|src_req1 |=> (flag1_q & $past(src_req1)) ==
		($past(src_req1) & `IEB_IMPL1))
	else $error("bank 1 flag missed a request");

	chk_flag_kept: assert property ( // R17 R18
		!(wr_fire && sel_fl0) |=>
		(flag0_q & $past(flag0_q)) == $past(flag0_q))
	else $error("bank 0 flag lost without a clear");

	chk_gate_opens: assert property ( // R1 R19 R4
		wr_fire && sel_en0 && wreq_q.strb[1] &&
		wreq_q.data[14] && flag0_q.dma_ch1_done_en |=>
		gated_req0.dma_ch1_done_en)
	else $error("enable write did not open the gate");

	chk_gate_blocks: assert property ( // R1 R16
		!en1_q.i2c_one_slave_en ##1 !en1_q.i2c_one_slave_en |->
		!gated_req1.i2c_one_slave_en &&
		!(irq && en0_q == 16'h0000 && en1_q == 16'h0000))
	else $error("disabled source passed through");

	chk_irq_source: assert property ( // R18
		$rose(irq) |-> |(flag0_q & en0_q) || |(flag1_q & en1_q))
	else $error("interrupt without flagged enabled source");

	chk_bresp_hold: assert property (
		bvalid && !bready |=> bvalid && $stable(bresp))
	else $error("write response dropped early");

	chk_read_answer: assert property (
		ar_take |=> rvalid ##0 rdata[31:16] == 16'h0000)
	else $error("read not answered next cycle");

	chk_flag0_sets: assert property ( // R17
		|src_req0 |=> (flag0_q & $past(src_req0)) ==
		($past(src_req0) & `IEB_IMPL0))
	else $error("bank 0 flag missed a request");

	chk_flag1_kept: assert property ( // R17 R18
		!(wr_fire && sel_fl1) |=>
		(flag1_q & $past(flag1_q)) == $past(flag1_q))
	else $error("bank 1 flag lost without a clear");

	// a source firing in the clearing cycle must keep its flag
	chk_flag_clears: assert property ( // R17
		wr_fire && sel_fl1 |=>
		(flag1_q & $past(clr1)) ==
		($past(src_req1) & $past(clr1) & `IEB_IMPL1))
	else $error("bank 1 flag clear wrong");

	chk_enable_keeps_flag: assert property ( // R18
		wr_fire && (sel_en0 || sel_en1) |=>
		(flag0_q & $past(flag0_q)) == $past(flag0_q) &&
		(flag1_q & $past(flag1_q)) == $past(flag1_q))
	else $error("enable write disturbed a flag");

	chk_en0_kept: assert property ( // R2 R19
		!(wr_fire && sel_en0) |=> $stable(en0_q))
	else $error("bank 0 enable moved without a write");

	chk_en1_kept: assert property ( // R2 R19
		!(wr_fire && sel_en1) |=> $stable(en1_q))
	else $error("bank 1 enable moved without a write");

	chk_unmapped_err: assert property (
		wr_fire && !wr_hit |=> bvalid && bresp == `IEB_RESP_SLVERR)
	else $error("unmapped write not refused");

	chk_en1_readback: assert property ( // R2 R3
		ar_take && araddr == `IEB_EN1_ADDR |=>
		rdata[15:0] == $past(en1_q) && rresp == `IEB_RESP_OKAY)
	else $error("bank 1 enable read back wrong");

endmodule : interrupt_enable_bank_lower

// [verilog/irq_enable_defs.svh]
// register map, field masks and reset values of the enable bank
`ifndef IRQ_ENABLE_DEFS_SVH
`define IRQ_ENABLE_DEFS_SVH

// ==========================================================
// byte addresses
`define IEB_EN0_ADDR 32'h0000_0000
`define IEB_EN1_ADDR 32'h0000_0004
`define IEB_FL0_ADDR 32'h0000_0008
`define IEB_FL1_ADDR 32'h0000_000C

// ==========================================================
// implemented bits and reset values
`define IEB_IMPL0 16'h7FFF
`define IEB_IMPL1 16'hFFFB
`define IEB_EN_RST 16'h0000
`define IEB_FL_RST 16'h0000

// ==========================================================
// bus answers
`define IEB_RESP_OKAY 2'h0
`define IEB_RESP_SLVERR 2'h2
`define IEB_RDATA_RST 32'h0000_0000

`endif

// [verilog/irq_enable_pkg.sv]
// types shared by the interrupt enable bank
package irq_enable_pkg;

	// ==========================================================
	// bank 0 layout, bit 15 first
	typedef struct packed {
		logic rsvd15;
		logic dma_ch1_done_en;
		logic adc_unit1_done_en;
		logic uart_one_tx_en;
		logic uart_one_rx_en;
		logic spi_one_event_en;
		logic spi_one_error_en;
		logic timer_three_en;
		logic timer_two_en;
		logic out_compare_two_en;
		logic in_capture_two_en;
		logic dma_ch0_done_en;
		logic timer_one_en;
		logic out_compare_one_en;
		logic in_capture_one_en;
		logic ext_pin0_irq_en;
	} bank0_t;

	// ==========================================================
	// bank 1 layout, bit 15 first
	typedef struct packed {
		logic uart_two_tx_en;
		logic uart_two_rx_en;
		logic ext_pin2_irq_en;
		logic timer_five_en;
		logic timer_four_en;
		logic out_compare_four_en;
		logic out_compare_three_en;
		logic dma_ch2_done_en;
		logic in_capture_eight_en;
		logic in_capture_seven_en;
		logic adc_unit2_done_en;
		logic ext_pin1_irq_en;
		logic pin_change_notify_en;
		logic rsvd2;
		logic i2c_one_master_en;
		logic i2c_one_slave_en;
	} bank1_t;

	// ==========================================================
	// held write request
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] data;
		logic [3:0] strb;
	} wr_req_t;

endpackage : irq_enable_pkg

// [sim/irq_vector_model.sv]
// processor-side model: takes the lowest pending source number
`timescale 1ns/1ps
module irq_vector_model
	import irq_enable_pkg::*;
(
	input wire logic irq,
	input wire bank0_t gated_req0,
	input wire bank1_t gated_req1,
	output logic [5:0] vector
);
	logic [31:0] pend;
	assign pend = {gated_req1, gated_req0};
	// ==========================================================
	// priority pick, 6'h3F means nothing to take
	always_comb begin
		vector = 6'h3F;
		for (int i = 31; i >= 0; i--) begin
			if (irq && pend[i]) begin
				vector = i[5:0];
			end
		end
	end
endmodule : irq_vector_model

// [sim/tb_interrupt_enable_bank_lower.sv]
// self-checking bench for the interrupt enable bank
`timescale 1ns/1ps
`include "irq_enable_defs.svh"
module tb_interrupt_enable_bank_lower
	import irq_enable_pkg::*;
;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, irq;
	logic [31:0] awaddr, wdata, araddr, rdata, fl, impl, d;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	logic [15:0] src_req0, src_req1;
	bank0_t gated_req0;
	bank1_t gated_req1;
	logic [5:0] vector;
	int fails, tests_run;

	interrupt_enable_bank_lower u_interrupt_enable_bank_lower (.aclk(aclk),
		.aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.src_req0(src_req0), .src_req1(src_req1), .gated_req0(gated_req0),
		.gated_req1(gated_req1), .irq(irq));
	irq_vector_model u_irq_vector_model (.irq(irq), .gated_req0(gated_req0),
		.gated_req1(gated_req1), .vector(vector));

	// ==========================================================
	// helpers
	task automatic check(input string n, input logic [31:0] e,
		input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : check

	function automatic logic [31:0] low_idx(input logic [31:0] v);
		low_idx = 32'h0000_003F;
		for (int i = 31; i >= 0; i--) begin
			if (v[i]) begin
				low_idx = i;
			end
		end
	endfunction : low_idx

	task automatic axi_write(input logic [31:0] a, input logic [31:0] v,
		output logic [1:0] resp);
		int i;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		resp = bresp;
		bready <= 1'b0;
		if (i == 50) check("write answer", 32'h0, 32'h1);
	endtask : axi_write

	task automatic axi_read(input logic [31:0] a, output logic [31:0] v,
		output logic [1:0] resp);
		int i;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		v = rdata;
		resp = rresp;
		rready <= 1'b0;
		if (i == 50) check("read answer", 32'h0, 32'h1);
	endtask : axi_read

	// flags first, then enables; the new flags meet the previous case's enables, so outputs can move before the enable writes
	task automatic run_case(input logic [31:0] en, input logic [31:0] src);
		logic [31:0] e;
		@(posedge aclk);
		src_req0 <= src[15:0];
		src_req1 <= src[31:16];
		@(posedge aclk);
		src_req0 <= 16'h0000;
		src_req1 <= 16'h0000;
		fl = fl | (src & impl);
		axi_write(`IEB_EN0_ADDR, {16'($urandom), en[15:0]}, r);
		check("en0 bresp", 32'(`IEB_RESP_OKAY), 32'(r));
		axi_write(`IEB_EN1_ADDR, {16'h0000, en[31:16]}, r);
		#1;
		e = fl & en & impl;
		check("gated", e, {gated_req1, gated_req0});
		check("irq", 32'(|e), 32'(irq));
		check("vector", low_idx(e), 32'(vector));
		axi_read(`IEB_FL0_ADDR, d, r);
		check("flag0", {16'h0000, fl[15:0]}, d);
		check("flag0 rresp", 32'(`IEB_RESP_OKAY), 32'(r));
		axi_read(`IEB_FL1_ADDR, d, r);
		check("flag1", {16'h0000, fl[31:16]}, d);
		axi_read(`IEB_EN0_ADDR, d, r);
		check("en0", {16'h0000, en[15:0] & impl[15:0]}, d);
		axi_read(`IEB_EN1_ADDR, d, r);
		check("en1", {16'h0000, en[31:16] & impl[31:16]}, d);
		axi_write(`IEB_FL0_ADDR, 32'h0000_FFFF, r);
		axi_write(`IEB_FL1_ADDR, 32'h0000_FFFF, r);
		fl = 32'h0000_0000;
	endtask : run_case

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : final_report

	// ==========================================================
	// clock, watchdog, main sequence
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	initial begin
		repeat (20000) @(posedge aclk);
		check("watchdog", 32'h0, 32'h1);
		final_report();
	end

	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{awaddr, wdata, araddr} = 96'h0;
		wstrb = 4'hF;
		{src_req0, src_req1} = 32'h0000_0000;
		{fails, tests_run} = 64'h0;
		impl = {`IEB_IMPL1, `IEB_IMPL0};
		fl = 32'h0000_0000;
		void'($urandom(32'h7583E0ED));
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		axi_read(`IEB_EN0_ADDR, d, r);
		check("en0 reset", 32'(`IEB_EN_RST), d);
		axi_read(`IEB_EN1_ADDR, d, r);
		check("en1 reset", 32'(`IEB_EN_RST), d);
		run_case(32'hFFFF_FFFF, 32'hFFFF_FFFF);
		// one source at a time, reserved positions included
		for (int b = 0; b < 32; b++) begin
			run_case(32'h1 << b, 32'h1 << b);
		end
		for (int k = 0; k < 24; k++) begin
			run_case($urandom, $urandom);
		end
		// byte lanes: only the strobed low byte moves
		axi_write(`IEB_EN1_ADDR, 32'h0000_FFFF, r);
		wstrb <= 4'h1;
		axi_write(`IEB_EN1_ADDR, 32'h0000_0000, r);
		wstrb <= 4'hF;
		axi_read(`IEB_EN1_ADDR, d, r);
		check("en1 lane", 32'h0000_FF00, d);
		axi_write(32'h0000_0010, 32'h0000_FFFF, r);
		check("unmapped bresp", 32'(`IEB_RESP_SLVERR), 32'(r));
		axi_read(32'h0000_0010, d, r);
		check("unmapped rresp", 32'(`IEB_RESP_SLVERR), 32'(r));
		check("unmapped rdata", 32'h0000_0000, d);
		axi_read(`IEB_EN1_ADDR, d, r);
		check("en1 kept", 32'h0000_FF00, d);
		// flags and enables set, then a reset in mid-run
		axi_write(`IEB_EN0_ADDR, 32'h0000_7FFF, r);
		src_req0 <= 16'hFFFF;
		@(posedge aclk);
		src_req0 <= 16'h0000;
		aresetn <= 1'b0;
		#1;
		check("irq before reset", 32'h1, 32'(irq));
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		axi_read(`IEB_EN0_ADDR, d, r);
		check("en0 rereset", 32'h0000_0000, d);
		axi_read(`IEB_FL0_ADDR, d, r);
		check("flag0 rereset", 32'h0000_0000, d);
		check("irq rereset", 32'h0, 32'(irq));
		final_report();
	end
endmodule : tb_interrupt_enable_bank_lower
